// ===== hdl/ipss_regs.svh
// Command codes, reset values and timing constants of the input-limit and sequencing bank
// Operation
// - Input over warning sets summary bits, alert
// - Input under warning sets summary bits, alert
// - Under fault holds until above warning level
// - Action 80h latches off, BFh retries 70ms
// - Good asserts after level plus delay
// - Good drops below output under warning
// - Enable waits turn-on delay before rising
// - Rise lasts programmed turn-on ramp time
// - Disable waits turn-off delay before falling
// - Fall lasts programmed turn-off ramp time
// - Summary bit 7 marks busy fault
// - Summary bit 6 set while output unpowered
// - Bits 5,4,3: output over, overcurrent, input under
// - Bit 2 temperature, bit 1 comm/memory/logic
// - Bit 0 catches all other conditions except power not good
// - Word low byte is the summary byte
// - Word bits 15..12: output, current, input, vendor
// - Word bits 11..8: not good, fan, other, unknown
// - Summary byte and word are read only
// - Limits, times two bytes; action one byte
// - Input status byte: bits 7,6,5,4
`ifndef IPSS_REGS_SVH
`define IPSS_REGS_SVH

`define IPSS_CMD_OVW      8'h57
`define IPSS_CMD_UVW      8'h58
`define IPSS_CMD_UVF      8'h59
`define IPSS_CMD_ACT      8'h5A
`define IPSS_CMD_PGON     8'h5E
`define IPSS_CMD_TON      8'h60
`define IPSS_CMD_TONR     8'h61
`define IPSS_CMD_TOFF     8'h64
`define IPSS_CMD_TOFFR    8'h65
`define IPSS_CMD_SBYTE    8'h78
`define IPSS_CMD_SWORD    8'h79
`define IPSS_CMD_SINPUT   8'h7C

`define IPSS_RST_OVW      16'hD353
`define IPSS_RST_UVW      16'h0000
`define IPSS_RST_UVF      16'h0000
`define IPSS_RST_ACT      8'h80
`define IPSS_RST_PGON     16'h0000
`define IPSS_RST_TIME     16'h0000
`define IPSS_RST_STATUS   8'h00

`define IPSS_ACT_LATCH    8'h80
`define IPSS_ACT_RETRY    8'hBF

`define IPSS_BUS_ADDR     7'h40
`define IPSS_IDLE_BYTE    8'hFF

`define IPSS_CLK_NS       10
`define IPSS_MS_NS        1000000
`define IPSS_RETRY_MS     16'd70

`endif

// ===== hdl/ipss_pkg.sv
// Types shared by the input-limit and sequencing bank
package ipss_pkg;

  typedef enum logic [2:0] {
    IPSS_OFF   = 3'b000,
    IPSS_TON   = 3'b001,
    IPSS_RISE  = 3'b011,
    IPSS_ON    = 3'b010,
    IPSS_TOFF  = 3'b110,
    IPSS_FALL  = 3'b111,
    IPSS_RETRY = 3'b101,
    IPSS_LATCH = 3'b100
  } ipss_seq_t;

  typedef enum logic [2:0] {
    IPSS_B_IDLE = 3'b000,
    IPSS_B_ADDR = 3'b001,
    IPSS_B_CMD  = 3'b011,
    IPSS_B_WR   = 3'b010,
    IPSS_B_RD   = 3'b110
  } ipss_bus_t;

  typedef struct packed {
    logic vout_any;
    logic vout_ov_fault;
    logic iout_any;
    logic iout_oc_fault;
    logic input_ov_fault;
    logic temp_any;
    logic comm_memory_logic_flag;
    logic vendor_specific_flag;
    logic fan_any;
    logic other_any;
    logic unknown_any;
  } ipss_ext_t;

  typedef struct packed {
    logic       stb;
    logic [7:0] cmd;
    logic [15:0] data;
  } ipss_wr_t;

endpackage

// ===== hdl/ipss_bank.sv
// Input limits, sequencing, power-good and summary status bank behind the management bus
`timescale 1ns/1ns
`default_nettype none
`include "ipss_regs.svh"

module ipss_bank #(
  parameter int unsigned MS_CYCLES = `IPSS_MS_NS / `IPSS_CLK_NS,
  parameter logic [6:0]  DEV_ADDR  = `IPSS_BUS_ADDR
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              pmb_scl_i,
  input  wire logic              pmb_sda_i,
  output logic                   pmb_sda_o,
  output logic                   pmb_sda_oe_o,
  output logic                   pmb_alert_n_o,
  input  wire logic              enable_i,
  input  wire logic [15:0]       vin_i,
  input  wire logic [15:0]       vout_i,
  input  wire logic [15:0]       output_undervolt_warn_threshold_i,
  input  wire logic [15:0]       good_delay_ms_i,
  input  wire logic              busy_fault_i,
  input  wire ipss_pkg::ipss_ext_t ext_i,
  output logic                   out_en_o,
  output logic                   ramp_up_o,
  output logic                   ramp_down_o,
  output logic                   power_good_o
);

  // Linear eleven format to signed fixed point, 16 fraction bits
  function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    e = v[15:11];
    m = {{21{v[10]}}, v[10:0], 16'h0000};
    if (e >= 0)
      lin_fix = m <<< e;
    else
      lin_fix = m >>> (-e);
  endfunction

  // Linear eleven time value to whole milliseconds, negatives read as zero
  function automatic logic [15:0] lin_ms(input logic [15:0] v);
    logic signed [47:0] f;
    f = lin_fix(v);
    if (f < 0)
      lin_ms = 16'h0000;
    else if (f[47:32] != 16'h0000)
      lin_ms = 16'hFFFF;
    else
      lin_ms = f[31:16];
  endfunction

  function automatic logic [1:0] cmd_len(input logic [7:0] c);
    unique case (c)
      `IPSS_CMD_ACT, `IPSS_CMD_SBYTE, `IPSS_CMD_SINPUT: cmd_len = 2'd1;
      `IPSS_CMD_OVW, `IPSS_CMD_UVW, `IPSS_CMD_UVF, `IPSS_CMD_PGON, `IPSS_CMD_TON,
      `IPSS_CMD_TONR, `IPSS_CMD_TOFF, `IPSS_CMD_TOFFR, `IPSS_CMD_SWORD: cmd_len = 2'd2;
      default: cmd_len = 2'd0;
    endcase
  endfunction

  function automatic logic cmd_ro(input logic [7:0] c);
    cmd_ro = (c == `IPSS_CMD_SBYTE) || (c == `IPSS_CMD_SWORD) || (c == `IPSS_CMD_SINPUT);
  endfunction

  // Settings
  logic [15:0] ovw_r, uvw_r, uvf_r, pgon_r, ton_r, tonr_r, toff_r, toffr_r;
  logic [7:0]  act_r;
  // Status
  logic [7:0]  sbyte_r;
  logic [7:0]  shigh_r;
  logic [7:0]  sinput_r;
  logic        busy_r;
  logic        uvf_flag_r;
  ipss_pkg::ipss_seq_t seq_r;
  logic        pg_r;

  // Bus side
  logic        scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
  ipss_pkg::ipss_bus_t phase_r;
  logic [3:0]  bitcnt_r;
  logic [7:0]  shin_r, shout_r, cmd_r, wlo_r;
  logic [1:0]  bidx_r;
  logic [15:0] rdw_r;
  logic        ack_r, mack_r, rw_r, rd_clr_r;
  ipss_pkg::ipss_wr_t wr_r;
  logic        en_q1, en_q2;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      {scl_q1, scl_q2, scl_q3} <= 3'b111;
      {sda_q1, sda_q2, sda_q3} <= 3'b111;
      {en_q1, en_q2} <= 2'b00;
    end else begin
      {scl_q1, scl_q2, scl_q3} <= {pmb_scl_i, scl_q1, scl_q2};
      {sda_q1, sda_q2, sda_q3} <= {pmb_sda_i, sda_q1, sda_q2};
      {en_q1, en_q2} <= {enable_i, en_q1};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_q2 & ~scl_q3;
  assign scl_fall  = ~scl_q2 & scl_q3;
  assign bus_start = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
  assign bus_stop  = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;

  logic [15:0] rd_mux;
  always_comb begin
    unique case (cmd_r)
      `IPSS_CMD_OVW:    rd_mux = ovw_r;
      `IPSS_CMD_UVW:    rd_mux = uvw_r;
      `IPSS_CMD_UVF:    rd_mux = uvf_r;
      `IPSS_CMD_ACT:    rd_mux = {8'h00, act_r};
      `IPSS_CMD_PGON:   rd_mux = pgon_r;
      `IPSS_CMD_TON:    rd_mux = ton_r;
      `IPSS_CMD_TONR:   rd_mux = tonr_r;
      `IPSS_CMD_TOFF:   rd_mux = toff_r;
      `IPSS_CMD_TOFFR:  rd_mux = toffr_r;
      `IPSS_CMD_SBYTE:  rd_mux = {`IPSS_IDLE_BYTE, sbyte_r};
      `IPSS_CMD_SWORD:  rd_mux = {shigh_r, sbyte_r};
      `IPSS_CMD_SINPUT: rd_mux = {`IPSS_IDLE_BYTE, sinput_r};
      default:          rd_mux = {`IPSS_IDLE_BYTE, `IPSS_IDLE_BYTE};
    endcase
  end

  logic [7:0] next_tx;
  assign next_tx = (bidx_r == 2'd0) ? rdw_r[7:0] : (bidx_r == 2'd1) ? rdw_r[15:8] : `IPSS_IDLE_BYTE;

  // Byte engine: bits sampled on rising clock, driven after falling clock
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      phase_r      <= ipss_pkg::IPSS_B_IDLE;
      bitcnt_r     <= 4'h0;
      shin_r       <= 8'h00;
      shout_r      <= 8'h00;
      cmd_r        <= 8'h00;
      wlo_r        <= 8'h00;
      bidx_r       <= 2'd0;
      rdw_r        <= 16'h0000;
      ack_r        <= 1'b0;
      mack_r       <= 1'b0;
      rw_r         <= 1'b0;
      rd_clr_r     <= 1'b0;
      wr_r         <= '0;
      pmb_sda_oe_o <= 1'b0;
    end else begin
      wr_r.stb <= 1'b0;
      rd_clr_r <= 1'b0;
      if (bus_start) begin
        phase_r      <= ipss_pkg::IPSS_B_ADDR;
        // The start's own clock fall wraps this to zero
        bitcnt_r     <= 4'hF;
        bidx_r       <= 2'd0;
        pmb_sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        phase_r      <= ipss_pkg::IPSS_B_IDLE;
        pmb_sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (bitcnt_r < 4'd8)
          shin_r <= {shin_r[6:0], sda_q2};
        else
          mack_r <= ~sda_q2;
      end else if (scl_fall && phase_r != ipss_pkg::IPSS_B_IDLE) begin
        if (bitcnt_r == 4'd7) begin
          bitcnt_r <= 4'd8;
          ack_r    <= 1'b0;
          pmb_sda_oe_o <= 1'b0;
          unique case (phase_r)
            ipss_pkg::IPSS_B_ADDR: begin
              if (shin_r[7:1] == DEV_ADDR) begin
                ack_r        <= 1'b1;
                pmb_sda_oe_o <= 1'b1;
                rw_r         <= shin_r[0];
                rdw_r        <= rd_mux;
                if (shin_r[0] && (cmd_r == `IPSS_CMD_SBYTE || cmd_r == `IPSS_CMD_SWORD))
                  rd_clr_r <= 1'b1;
              end
            end
            ipss_pkg::IPSS_B_CMD: begin
              cmd_r <= shin_r;
              if (cmd_len(shin_r) != 2'd0) begin
                ack_r        <= 1'b1;
                pmb_sda_oe_o <= 1'b1;
              end
            end
            ipss_pkg::IPSS_B_WR: begin
              // Writes to read-only or past the last byte are refused
              if (!cmd_ro(cmd_r) && ({1'b0, bidx_r} < {1'b0, cmd_len(cmd_r)})) begin
                ack_r        <= 1'b1;
                pmb_sda_oe_o <= 1'b1;
                if (bidx_r == 2'd0)
                  wlo_r <= shin_r;
                if (bidx_r == cmd_len(cmd_r) - 2'd1) begin
                  wr_r.stb  <= 1'b1;
                  wr_r.cmd  <= cmd_r;
                  wr_r.data <= (bidx_r == 2'd0) ? {8'h00, shin_r} : {shin_r, wlo_r};
                end
              end
            end
            default: ;
          endcase
        end else if (bitcnt_r == 4'd8) begin
          bitcnt_r     <= 4'h0;
          pmb_sda_oe_o <= 1'b0;
          unique case (phase_r)
            ipss_pkg::IPSS_B_ADDR: begin
              if (!ack_r)
                phase_r <= ipss_pkg::IPSS_B_IDLE;
              else if (rw_r) begin
                phase_r      <= ipss_pkg::IPSS_B_RD;
                shout_r      <= rdw_r[7:0];
                pmb_sda_oe_o <= ~rdw_r[7];
                bidx_r       <= 2'd1;
              end else
                phase_r <= ipss_pkg::IPSS_B_CMD;
            end
            ipss_pkg::IPSS_B_CMD:
              phase_r <= ack_r ? ipss_pkg::IPSS_B_WR : ipss_pkg::IPSS_B_IDLE;
            ipss_pkg::IPSS_B_WR: begin
              if (!ack_r)
                phase_r <= ipss_pkg::IPSS_B_IDLE;
              else
                bidx_r <= bidx_r + 2'd1;
            end
            ipss_pkg::IPSS_B_RD: begin
              if (!mack_r)
                phase_r <= ipss_pkg::IPSS_B_IDLE;
              else begin
                shout_r      <= next_tx;
                pmb_sda_oe_o <= ~next_tx[7];
                if (bidx_r != 2'd3)
                  bidx_r <= bidx_r + 2'd1;
              end
            end
            default: ;
          endcase
        end else begin
          bitcnt_r <= bitcnt_r + 4'h1;
          if (phase_r == ipss_pkg::IPSS_B_RD) begin
            shout_r      <= {shout_r[6:0], 1'b1};
            pmb_sda_oe_o <= ~shout_r[6];
          end
        end
      end
    end
  end

  // Open drain: the line is only ever pulled low
  always_ff @(posedge core_clk_i) begin
    pmb_sda_o <= 1'b0;
  end

  // Writable settings
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ovw_r   <= `IPSS_RST_OVW;
      uvw_r   <= `IPSS_RST_UVW;
      uvf_r   <= `IPSS_RST_UVF;
      act_r   <= `IPSS_RST_ACT;
      pgon_r  <= `IPSS_RST_PGON;
      ton_r   <= `IPSS_RST_TIME;
      tonr_r  <= `IPSS_RST_TIME;
      toff_r  <= `IPSS_RST_TIME;
      toffr_r <= `IPSS_RST_TIME;
    end else if (wr_r.stb) begin
      unique case (wr_r.cmd)
        `IPSS_CMD_OVW:   ovw_r   <= wr_r.data;
        `IPSS_CMD_UVW:   uvw_r   <= wr_r.data;
        `IPSS_CMD_UVF:   uvf_r   <= wr_r.data;
        `IPSS_CMD_ACT:   act_r   <= wr_r.data[7:0];
        `IPSS_CMD_PGON:  pgon_r  <= wr_r.data;
        `IPSS_CMD_TON:   ton_r   <= wr_r.data;
        `IPSS_CMD_TONR:  tonr_r  <= wr_r.data;
        `IPSS_CMD_TOFF:  toff_r  <= wr_r.data;
        `IPSS_CMD_TOFFR: toffr_r <= wr_r.data;
        default: ;
      endcase
    end
  end

  // Millisecond tick
  logic [31:0] div_r;
  logic        ms_tick;
  assign ms_tick = (div_r == MS_CYCLES - 1);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || ms_tick)
      div_r <= 32'h0;
    else
      div_r <= div_r + 32'h1;
  end

  // Input limit comparisons
  logic signed [47:0] vin_fx;
  logic in_ovw, in_uvw, in_uvf_trip, in_uvf_clr;
  assign vin_fx      = lin_fix(vin_i);
  assign in_ovw      = vin_fx > lin_fix(ovw_r);
  assign in_uvw      = vin_fx < lin_fix(uvw_r);
  assign in_uvf_trip = vin_fx < lin_fix(uvf_r);
  assign in_uvf_clr  = vin_fx > lin_fix(uvw_r);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i)
      uvf_flag_r <= 1'b0;
    else if (in_uvf_trip)
      uvf_flag_r <= 1'b1;
    else if (in_uvf_clr)
      uvf_flag_r <= 1'b0;
  end

  // Sequencer
  logic [15:0] mscnt_r;
  logic        powering;
  logic        seq_done;
  logic [15:0] seq_target;
  always_comb begin
    unique case (seq_r)
      ipss_pkg::IPSS_TON:   seq_target = lin_ms(ton_r);
      ipss_pkg::IPSS_RISE:  seq_target = lin_ms(tonr_r);
      ipss_pkg::IPSS_TOFF:  seq_target = lin_ms(toff_r);
      ipss_pkg::IPSS_FALL:  seq_target = lin_ms(toffr_r);
      ipss_pkg::IPSS_RETRY: seq_target = `IPSS_RETRY_MS;
      default:              seq_target = 16'h0000;
    endcase
  end
  assign seq_done = (mscnt_r >= seq_target);
  assign powering = (seq_r == ipss_pkg::IPSS_RISE) || (seq_r == ipss_pkg::IPSS_ON) ||
                    (seq_r == ipss_pkg::IPSS_TOFF) || (seq_r == ipss_pkg::IPSS_FALL);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      seq_r   <= ipss_pkg::IPSS_OFF;
      mscnt_r <= 16'h0000;
    end else if (uvf_flag_r && seq_r != ipss_pkg::IPSS_OFF && seq_r != ipss_pkg::IPSS_RETRY &&
                 seq_r != ipss_pkg::IPSS_LATCH) begin
      // Fault cuts the output at once, no soft-off
      seq_r   <= (act_r == `IPSS_ACT_RETRY) ? ipss_pkg::IPSS_RETRY : ipss_pkg::IPSS_LATCH;
      mscnt_r <= 16'h0000;
    end else begin
      if (ms_tick && !seq_done)
        mscnt_r <= mscnt_r + 16'h1;
      unique case (seq_r)
        ipss_pkg::IPSS_OFF: if (en_q2 && !uvf_flag_r) begin
          seq_r   <= ipss_pkg::IPSS_TON;
          mscnt_r <= 16'h0000;
        end
        ipss_pkg::IPSS_TON: begin
          if (!en_q2)
            seq_r <= ipss_pkg::IPSS_OFF;
          else if (seq_done) begin
            seq_r   <= ipss_pkg::IPSS_RISE;
            mscnt_r <= 16'h0000;
          end
        end
        ipss_pkg::IPSS_RISE: if (seq_done) seq_r <= ipss_pkg::IPSS_ON;
        ipss_pkg::IPSS_ON: if (!en_q2) begin
          seq_r   <= ipss_pkg::IPSS_TOFF;
          mscnt_r <= 16'h0000;
        end
        ipss_pkg::IPSS_TOFF: if (seq_done) begin
          seq_r   <= ipss_pkg::IPSS_FALL;
          mscnt_r <= 16'h0000;
        end
        ipss_pkg::IPSS_FALL: if (seq_done) seq_r <= ipss_pkg::IPSS_OFF;
        ipss_pkg::IPSS_RETRY: begin
          // Retry only once the fault has cleared and the wait is over
          if (!en_q2)
            seq_r <= ipss_pkg::IPSS_OFF;
          else if (seq_done) begin
            mscnt_r <= 16'h0000;
            if (!uvf_flag_r)
              seq_r <= ipss_pkg::IPSS_TON;
          end
        end
        ipss_pkg::IPSS_LATCH: if (!en_q2) seq_r <= ipss_pkg::IPSS_OFF;
        default: seq_r <= ipss_pkg::IPSS_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      out_en_o    <= 1'b0;
      ramp_up_o   <= 1'b0;
      ramp_down_o <= 1'b0;
    end else begin
      out_en_o    <= powering;
      ramp_up_o   <= (seq_r == ipss_pkg::IPSS_RISE);
      ramp_down_o <= (seq_r == ipss_pkg::IPSS_FALL);
    end
  end

  // Power-good with assert delay and lower release level
  logic [15:0] pgcnt_r;
  logic        pg_above;
  assign pg_above = powering && (vout_i > pgon_r);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pg_r    <= 1'b0;
      pgcnt_r <= 16'h0000;
    end else if (!powering || vout_i < output_undervolt_warn_threshold_i) begin
      pg_r    <= 1'b0;
      pgcnt_r <= 16'h0000;
    end else if (!pg_r && pg_above) begin
      if (pgcnt_r >= good_delay_ms_i)
        pg_r <= 1'b1;
      else if (ms_tick)
        pgcnt_r <= pgcnt_r + 16'h1;
    end else if (!pg_r)
      pgcnt_r <= 16'h0000;
  end
  assign power_good_o = pg_r;

  // Busy fault: set wins over the clear done by a status read
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i)
      busy_r <= 1'b0;
    else if (busy_fault_i)
      busy_r <= 1'b1;
    else if (rd_clr_r)
      busy_r <= 1'b0;
  end

  // Status registers, refreshed every cycle from live flags
  logic [7:0] sinput_n, sbyte_n, shigh_n;
  always_comb begin
    sinput_n = {ext_i.input_ov_fault, in_ovw, in_uvw, uvf_flag_r, 4'h0};
    sbyte_n  = {busy_r, ~powering, ext_i.vout_ov_fault, ext_i.iout_oc_fault, uvf_flag_r,
                ext_i.temp_any, ext_i.comm_memory_logic_flag,
                in_ovw | in_uvw | ext_i.input_ov_fault | ext_i.vendor_specific_flag |
                ext_i.fan_any | ext_i.other_any | ext_i.unknown_any | ext_i.vout_any | ext_i.iout_any};
    shigh_n  = {ext_i.vout_any | ext_i.vout_ov_fault, ext_i.iout_any | ext_i.iout_oc_fault,
                |sinput_n, ext_i.vendor_specific_flag,
                ~pg_r, ext_i.fan_any, ext_i.other_any, ext_i.unknown_any};
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sinput_r      <= `IPSS_RST_STATUS;
      sbyte_r       <= `IPSS_RST_STATUS;
      shigh_r       <= `IPSS_RST_STATUS;
      pmb_alert_n_o <= 1'b1;
    end else begin
      sinput_r      <= sinput_n;
      sbyte_r       <= sbyte_n;
      shigh_r       <= shigh_n;
      pmb_alert_n_o <= ~(|sbyte_n[7:0] & ~(sbyte_n == 8'h40) | |sinput_n);
    end
  end

endmodule

`default_nettype wire

// ===== bench/ipss_bank_asserts.sv
// Port-level assertions for the input-limit and sequencing bank
`timescale 1ns/1ns
`default_nettype none
module ipss_bank_asserts #(
  parameter int unsigned MS_CYCLES = 20,
  parameter logic [6:0]  DEV_ADDR  = 7'h40
) (
  input wire logic                core_clk_i,
  input wire logic                sys_rst_i,
  input wire logic                pmb_scl_i,
  input wire logic                pmb_sda_i,
  input wire logic                pmb_sda_o,
  input wire logic                pmb_sda_oe_o,
  input wire logic                pmb_alert_n_o,
  input wire logic                enable_i,
  input wire logic [15:0]         vin_i,
  input wire logic [15:0]         vout_i,
  input wire logic [15:0]         output_undervolt_warn_threshold_i,
  input wire logic [15:0]         good_delay_ms_i,
  input wire logic                busy_fault_i,
  input wire ipss_pkg::ipss_ext_t ext_i,
  input wire logic                out_en_o,
  input wire logic                ramp_up_o,
  input wire logic                ramp_down_o,
  input wire logic                power_good_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_good_powered: assert property ($rose(power_good_o) |-> out_en_o)
    else $error("power good rose while unpowered");
  a_good_drop: assert property (power_good_o && vout_i < output_undervolt_warn_threshold_i |=> !power_good_o)
    else $error("power good held below release level");
  a_ramp_apart: assert property (!(ramp_up_o && ramp_down_o))
    else $error("both ramps active");
  a_rise_powered: assert property (ramp_up_o |-> out_en_o)
    else $error("rise ramp while unpowered");
  a_fall_powered: assert property (ramp_down_o |-> out_en_o)
    else $error("fall ramp while unpowered");
  a_on_enabled: assert property ($rose(out_en_o) |-> $past(enable_i, 2))
    else $error("output powered without enable");
  a_fall_disabled: assert property ($rose(ramp_down_o) |-> !$past(enable_i, 2))
    else $error("fall ramp while enabled");
  a_busy_alert: assert property (busy_fault_i |-> ##[1:4] !pmb_alert_n_o)
    else $error("busy fault raised no alert");
  a_status_alert: assert property ((|ext_i) |-> ##[1:4] !pmb_alert_n_o)
    else $error("status condition raised no alert");
endmodule
`default_nettype wire

// ===== bench/ipss_host.sv
// Management-bus host model, open-drain bit-banged master
`timescale 1ns/1ns
`default_nettype none
module ipss_host #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // Serial clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = !b;
    #31 scl_o = 1'b1;
    #31 r = sda_i;
    #32 scl_o = 1'b0;
    #31;
  endtask
  task automatic start();
    sda_oe_o = 1'b0;
    #31 scl_o = 1'b1;
    #31 sda_oe_o = 1'b1;
    #31 scl_o = 1'b0;
    #32;
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    #31 scl_o = 1'b1;
    #31 sda_oe_o = 1'b0;
    #63;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(a, ack);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input int n, output logic nack);
    logic [7:0] r;
    logic       a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, nack);
    xfer(cmd, 1'b1, r, a);
    nack |= a;
    // Low byte first
    for (int i = 0; i < n; i++) begin
      xfer(v[8*i+:8], 1'b1, r, a);
      nack |= a;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] v);
    logic [7:0] r;
    logic       a;
    v = 16'h0000;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer(cmd, 1'b1, r, a);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
    // Last byte answered with a not-acknowledge
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, r, a);
      v[8*i+:8] = r;
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ===== bench/ipss_bank_bench.sv
// Self-checking bench of the input-limit and sequencing bank
`timescale 1ns/1ns
`default_nettype none
module ipss_bank_bench;
  localparam int MS = 20;
  logic                core_clk_i, sys_rst_i, enable_i, busy_fault_i, host_oe, pmb_scl_i;
  logic                pmb_sda_o, pmb_sda_oe_o, pmb_alert_n_o, out_en_o, ramp_up_o, ramp_down_o, power_good_o;
  logic [15:0]         vin_i, vout_i, output_undervolt_warn_threshold_i, good_delay_ms_i, v;
  ipss_pkg::ipss_ext_t ext_i;
  wire logic           pmb_sda_i;
  int                  failures, checked, cyc;
  logic [7:0]          rw [7] = '{8'h58, 8'h59, 8'h5E, 8'h60, 8'h61, 8'h64, 8'h65};
  // Pulled-up data line, low when either party drives
  assign pmb_sda_i = (pmb_sda_oe_o ? pmb_sda_o : 1'b1) & !host_oe;
  ipss_bank #(.MS_CYCLES(MS)) uut (.core_clk_i, .sys_rst_i, .pmb_scl_i, .pmb_sda_i, .pmb_sda_o, .pmb_sda_oe_o,
    .pmb_alert_n_o, .enable_i, .vin_i, .vout_i, .output_undervolt_warn_threshold_i, .good_delay_ms_i,
    .busy_fault_i, .ext_i, .out_en_o, .ramp_up_o, .ramp_down_o, .power_good_o);
  ipss_host host (.sda_i(pmb_sda_i), .scl_o(pmb_scl_i), .sda_oe_o(host_oe));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Millisecond ticks may land up to k ms early
  task automatic near(input int n, input int exp, input int k);
    check(16'(n >= exp - k * MS && n <= exp + 10), 16'h0001);
  endtask
  task automatic await(ref logic s, input logic lvl, output int n);
    n = 0;
    while (s !== lvl && n < 5000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic results();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      results();
    end
  end
  initial begin
    logic [31:0] s;
    logic        nk;
    int          n;
    s = 32'hC36D;
    {sys_rst_i, enable_i, busy_fault_i, vout_i} = {3'b100, 16'h0000};
    {vin_i, output_undervolt_warn_threshold_i, good_delay_ms_i} = {16'hD300, 16'h0180, 16'h0002};
    ext_i = '0;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    host.rd(8'h57, 2, v);
    check(v, 16'hD353);
    host.rd(8'h5A, 1, v);
    check(v, 16'h0080);
    host.rd(8'h78, 1, v);
    check(v, 16'h0040);
    host.rd(8'h79, 2, v);
    check(v, 16'h0840);
    host.rd(8'h99, 2, v);
    check(v, 16'hFFFF);
    @(posedge core_clk_i);
    busy_fault_i <= 1'b1;
    @(posedge core_clk_i);
    busy_fault_i <= 1'b0;
    host.rd(8'h78, 1, v);
    check(v, 16'h00C0);
    host.rd(8'h78, 1, v);
    check(v, 16'h0040);
    $display("end of reset values");
    foreach (rw[i]) begin
      s = lfsr(s);
      host.wr(rw[i], s[15:0], 2, nk);
      host.rd(rw[i], 2, v);
      check(v, s[15:0]);
    end
    s = lfsr(s);
    host.wr(8'h5A, {8'h00, s[7:0]}, 1, nk);
    host.rd(8'h5A, 1, v);
    check(v, {8'h00, s[7:0]});
    host.wr(8'h58, 16'hD2C0, 2, nk);
    host.wr(8'h59, 16'hD280, 2, nk);
    for (int i = 1; i <= 2; i++) begin
      host.wr(8'h77 + 8'(i), 16'h3FFF, i, nk);
      check({15'h0000, nk}, 16'h0001);
      host.rd(8'h78, 1, v);
      check(v, 16'h0040);
    end
    $display("end of register access");
    host.wr(8'h57, 16'hD200, 2, nk);
    host.rd(8'h79, 2, v);
    check(v, 16'h2841);
    host.rd(8'h7C, 1, v);
    check(v, 16'h0040);
    check({15'h0000, pmb_alert_n_o}, 16'h0000);
    host.wr(8'h57, 16'hD353, 2, nk);
    host.rd(8'h79, 2, v);
    check(v, 16'h0840);
    @(posedge core_clk_i);
    ext_i <= '1;
    host.rd(8'h79, 2, v);
    check(v, 16'hFF77);
    @(posedge core_clk_i);
    ext_i <= 11'h400;
    host.rd(8'h79, 2, v);
    check(v, 16'h8841);
    @(posedge core_clk_i);
    ext_i <= '0;
    host.wr(8'h58, 16'hD380, 2, nk);
    host.wr(8'h59, 16'hD380, 2, nk);
    host.wr(8'h59, 16'h0001, 2, nk);
    host.rd(8'h7C, 1, v);
    check(v, 16'h0030);
    host.rd(8'h78, 1, v);
    check(v, 16'h0049);
    $display("end of input warning");
    foreach (rw[i]) host.wr(rw[i], 16'h0100 >> (i == 2 ? 0 : 8), 2, nk);
    host.wr(8'h60, 16'h0005, 2, nk);
    host.wr(8'h61, 16'h0003, 2, nk);
    @(posedge core_clk_i);
    vout_i <= 16'h0200;
    enable_i <= 1'b1;
    await(out_en_o, 1'b1, n);
    near(n, 5 * MS + 6, 1);
    check({15'h0000, ramp_up_o}, 16'h0001);
    await(ramp_up_o, 1'b0, n);
    near(n, 3 * MS, 1);
    check({15'h0000, power_good_o}, 16'h0001);
    host.rd(8'h79, 2, v);
    check(v, 16'h0000);
    @(posedge core_clk_i);
    vout_i <= 16'h0100;
    repeat (2) @(negedge core_clk_i);
    check({15'h0000, power_good_o}, 16'h0000);
    @(posedge core_clk_i);
    enable_i <= 1'b0;
    await(ramp_down_o, 1'b1, n);
    near(n, MS + 6, 1);
    await(out_en_o, 1'b0, n);
    near(n, MS, 1);
    $display("end of sequencing");
    results();
  end
endmodule
bind ipss_bank ipss_bank_asserts #(.MS_CYCLES(MS_CYCLES), .DEV_ADDR(DEV_ADDR)) chk (.core_clk_i, .sys_rst_i,
  .pmb_scl_i, .pmb_sda_i, .pmb_sda_o, .pmb_sda_oe_o, .pmb_alert_n_o, .enable_i, .vin_i, .vout_i,
  .output_undervolt_warn_threshold_i, .good_delay_ms_i, .busy_fault_i, .ext_i, .out_en_o, .ramp_up_o,
  .ramp_down_o, .power_good_o);
`default_nettype wire
